/* common/tir_pkg.sv */
// package for the interrupt request block: register map, field layout,
// reset values and mode encodings.
// assumes a 32-bit AXI4-Lite slave with 8-bit registers in the low byte.
package tir_pkg;

  // ************************************************************
  // bus and register map
  // ************************************************************
  localparam int          DATA_W      = 32;
  localparam int          ADDR_W      = 8;
  localparam int          REG_W       = 8;
  localparam int          N_SRC       = 8;
  localparam logic [5:0]  IDX_ENABLE  = 6'h04;
  localparam logic [5:0]  IDX_REQUEST = 6'h05;
  localparam logic [5:0]  IDX_MODE    = 6'h06;
  localparam logic [5:0]  IDX_COUNT_L = 6'h08;
  localparam logic [5:0]  IDX_COUNT_H = 6'h09;
  localparam logic [5:0]  IDX_EDGE    = 6'h0C;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ************************************************************
  // source bit positions in request and enable registers
  // ************************************************************
  localparam int SRC_TIMER_THREE = 7;
  localparam int SRC_TIMER_TWO = 6;
  localparam int SRC_PWM    = 5;
  localparam int SRC_CMP    = 4;
  localparam int SRC_ADC    = 3;
  localparam int SRC_CNT    = 2;
  localparam int SRC_PAIR1  = 1;
  localparam int SRC_PAIR2  = 0;

  // ************************************************************
  // field layout and reset values
  // ************************************************************
  localparam int         MODE_SRC_LSB = 5;
  localparam int         MODE_DIV_LSB = 3;
  localparam int         MODE_BIT_LSB = 0;
  localparam int         EDGE_CNT_BIT = 4;
  localparam int         EDGE_P1_LSB  = 2;
  localparam int         EDGE_P2_LSB  = 0;
  localparam int         EDGE_W       = 5;
  localparam int         CNT_W        = 16;
  localparam int         CNT_SEL_BASE = 8;
  localparam int         PRE_W        = 6;
  localparam logic [5:0] PRE_TERM_1   = 6'h00;
  localparam logic [5:0] PRE_TERM_4   = 6'h03;
  localparam logic [5:0] PRE_TERM_16  = 6'h0F;
  localparam logic [5:0] PRE_TERM_64  = 6'h3F;
  localparam logic [7:0] RST_REG      = 8'h00;

  typedef enum logic [2:0] {
    CS_STOP   = 3'h0,
    CS_SYS    = 3'h1,
    CS_RSVD   = 3'h2,
    CS_PIN_A4 = 3'h3,
    CS_HRC    = 3'h4,
    CS_EXTERNAL_OSCILLATOR   = 3'h5,
    CS_LRC    = 3'h6,
    CS_PIN_A0 = 3'h7
  } tir_clksrc_t;

  typedef enum logic [1:0] {
    EM_BOTH = 2'h0,
    EM_RISE = 2'h1,
    EM_FALL = 2'h2,
    EM_RSVD = 2'h3
  } tir_edge_t;

  typedef enum logic [1:0] {
    WS_COLLECT = 2'b01,
    WS_RESP    = 2'b10
  } tir_wst_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'b01,
    RS_DATA = 2'b10
  } tir_rdst_t;

  // byte address of a register index
  function automatic logic [ADDR_W-1:0] byte_addr(input logic [5:0] idx);
    return {idx, 2'h0};
  endfunction

endpackage

/* logic/tir_edge.sv */
// edge detector for one level source with a selectable sensitivity.
// assumes the level is synchronous to CLK_I.
`timescale 1ns/1ps
`default_nettype none
module tir_edge (
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // source and sensitivity
  input  wire logic              level_i,
  input  wire tir_pkg::tir_edge_t mode_i,
  // one-cycle event
  output logic                   pulse_o
);
  import tir_pkg::*;

  typedef struct packed {
    logic prev;
  } tir_edge_state_t;

  tir_edge_state_t r;
  tir_edge_state_t next_r;
  logic            rise;
  logic            fall;

  // compare the sample with the one of the previous clock
  always_comb begin
    next_r      = r;
    next_r.prev = level_i;
    rise        = level_i & ~r.prev;
    fall        = ~level_i & r.prev;
    unique case (mode_i)
      EM_BOTH: pulse_o = rise | fall;
      EM_RISE: pulse_o = rise;
      EM_FALL: pulse_o = fall;
      EM_RSVD: pulse_o = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

/* logic/tir_counter.sv */
// sixteen-bit counter with clock source select and pre-divider.
// assumes source ticks are one-cycle pulses synchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module tir_counter #(
  parameter int CW = tir_pkg::CNT_W
) (
  // clock and reset
  input  wire logic                clk_i,
  input  wire logic                rst_b_i,
  // configuration
  input  wire tir_pkg::tir_clksrc_t src_i,
  input  wire logic [1:0]          div_i,
  // count sources
  input  wire logic                hrc_tick_i,
  input  wire logic                external_oscillator_tick_i,
  input  wire logic                lrc_tick_i,
  input  wire logic                pin_a4_i,
  input  wire logic                pin_a0_i,
  // count value
  output logic [CW-1:0]            count_o
);
  import tir_pkg::*;

  typedef struct packed {
    logic [CW-1:0]    cnt;
    logic [PRE_W-1:0] pre;
    logic             a4_prev;
    logic             a0_prev;
  } tir_cnt_state_t;

  tir_cnt_state_t   r;
  tir_cnt_state_t   next_r;
  logic             tick;
  logic [PRE_W-1:0] term;

  always_comb begin
    next_r         = r;
    next_r.a4_prev = pin_a4_i;
    next_r.a0_prev = pin_a0_i;
    unique case (src_i)
      CS_STOP:   tick = 1'b0;
      CS_SYS:    tick = 1'b1;
      CS_RSVD:   tick = 1'b0;
      CS_PIN_A4: tick = r.a4_prev & ~pin_a4_i;
      CS_HRC:    tick = hrc_tick_i;
      CS_EXTERNAL_OSCILLATOR:   tick = external_oscillator_tick_i;
      CS_LRC:    tick = lrc_tick_i;
      CS_PIN_A0: tick = r.a0_prev & ~pin_a0_i;
    endcase
    unique case (div_i)
      2'h0: term = PRE_TERM_1;
      2'h1: term = PRE_TERM_4;
      2'h2: term = PRE_TERM_16;
      2'h3: term = PRE_TERM_64;
    endcase
    // >= so a shorter divide chosen mid-count cannot stall the counter
    if (tick) begin
      if (r.pre >= term) begin
        next_r.pre = '0;
        next_r.cnt = r.cnt + CW'(1);
      end else begin
        next_r.pre = r.pre + PRE_W'(1);
      end
    end
  end

  assign count_o = r.cnt;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

endmodule
`default_nettype wire

/* logic/tir_top.sv */
// interrupt request collection with AXI4-Lite register access, the
// sixteen-bit counter and its event select, and pin pair edge select.
// assumes every input is synchronous to CLK_I and event inputs are
// one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

module tir_top (
  // clock and reset
  input  wire logic                        CLK_I,
  input  wire logic                        RST_B_I,
  // axi4-lite write address and data
  input  wire logic                        AWVALID_I,
  output logic                             AWREADY_O,
  input  wire logic [tir_pkg::ADDR_W-1:0]  AWADDR_I,
  input  wire logic                        WVALID_I,
  output logic                             WREADY_O,
  input  wire logic [tir_pkg::DATA_W-1:0]  WDATA_I,
  input  wire logic [3:0]                  WSTRB_I,
  // axi4-lite write response
  output logic                             BVALID_O,
  input  wire logic                        BREADY_I,
  output logic [1:0]                       BRESP_O,
  // axi4-lite read
  input  wire logic                        ARVALID_I,
  output logic                             ARREADY_O,
  input  wire logic [tir_pkg::ADDR_W-1:0]  ARADDR_I,
  output logic                             RVALID_O,
  input  wire logic                        RREADY_I,
  output logic [tir_pkg::DATA_W-1:0]       RDATA_O,
  output logic [1:0]                       RRESP_O,
  // peripheral events, one-cycle pulses
  input  wire logic                        TIMER_THREE_EVT_I,
  input  wire logic                        TIMER_TWO_EVT_I,
  input  wire logic                        PWM_EVT_I,
  input  wire logic                        CMP_EVT_I,
  input  wire logic                        ADC_EVT_I,
  // counter clock ticks, one-cycle pulses
  input  wire logic                        HRC_TICK_I,
  input  wire logic                        EXTERNAL_OSCILLATOR_TICK_I,
  input  wire logic                        LRC_TICK_I,
  // pin levels and pair selection
  input  wire logic                        PIN_B0_I,
  input  wire logic                        PIN_A4_I,
  input  wire logic                        PIN_A0_I,
  input  wire logic                        PIN_B5_I,
  input  wire logic                        PAIR1_USE_A4_I,
  input  wire logic                        PAIR2_USE_B5_I,
  // interrupt to the core
  output logic                             IRQ_O
);
  import tir_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [REG_W-1:0]  en;
    logic [REG_W-1:0]  req;
    logic [REG_W-1:0]  mode;
    logic [EDGE_W-1:0] edge_sel;
    tir_wst_t          wst;
    logic              aw_got;
    logic              w_got;
    logic [ADDR_W-1:0] waddr;
    logic [REG_W-1:0]  wdata;
    logic              wlane;
    logic [1:0]        bresp;
    tir_rdst_t         rdst;
    logic [REG_W-1:0]  rdata;
    logic [1:0]        rresp;
  } tir_state_t;

  localparam tir_state_t RESET_STATE = '{
    en:       RST_REG,
    req:      RST_REG,
    mode:     RST_REG,
    edge_sel: RST_REG[EDGE_W-1:0],
    wst:      WS_COLLECT,
    aw_got:   1'b0,
    w_got:    1'b0,
    waddr:    '0,
    wdata:    RST_REG,
    wlane:    1'b0,
    bresp:    RESP_OKAY,
    rdst:     RS_IDLE,
    rdata:    RST_REG,
    rresp:    RESP_OKAY
  };

  tir_state_t       r;
  tir_state_t       next_r;
  logic [N_SRC-1:0] set_vec;
  logic [N_SRC-1:0] clr_vec;
  logic [CNT_W-1:0] count;
  logic             sel_bit;
  logic             cnt_pulse;
  logic             pair1_lvl;
  logic             pair2_lvl;
  logic             pair1_pulse;
  logic             pair2_pulse;
  logic             wr_do;
  tir_edge_t        cnt_mode;

  // ************************************************************
  // decode helpers
  // ************************************************************
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return a == byte_addr(IDX_ENABLE) || a == byte_addr(IDX_REQUEST) ||
           a == byte_addr(IDX_MODE) || a == byte_addr(IDX_EDGE) ||
           a == byte_addr(IDX_COUNT_L) || a == byte_addr(IDX_COUNT_H);
  endfunction

  // edge register is write only and reads back as zero
  function automatic logic [REG_W-1:0] read_mux(
    input logic [ADDR_W-1:0] a, input tir_state_t s,
    input logic [CNT_W-1:0] c);
    logic [REG_W-1:0] v;
    v = '0;
    if (a == byte_addr(IDX_ENABLE)) begin
      v = s.en;
    end else if (a == byte_addr(IDX_REQUEST)) begin
      v = s.req;
    end else if (a == byte_addr(IDX_MODE)) begin
      v = s.mode;
    end else if (a == byte_addr(IDX_COUNT_L)) begin
      v = c[REG_W-1:0];
    end else if (a == byte_addr(IDX_COUNT_H)) begin
      v = c[CNT_W-1:REG_W];
    end
    return v;
  endfunction

  // ************************************************************
  // counter and event sources
  // ************************************************************
  tir_counter #(
    .CW (CNT_W)
  ) u_counter (
    .clk_i        (CLK_I),
    .rst_b_i      (RST_B_I),
    .src_i        (tir_clksrc_t'(r.mode[MODE_SRC_LSB +: 3])),
    .div_i        (r.mode[MODE_DIV_LSB +: 2]),
    .hrc_tick_i   (HRC_TICK_I),
    .external_oscillator_tick_i  (EXTERNAL_OSCILLATOR_TICK_I),
    .lrc_tick_i   (LRC_TICK_I),
    .pin_a4_i     (PIN_A4_I),
    .pin_a0_i     (PIN_A0_I),
    .count_o      (count)
  );

  assign sel_bit  = count[CNT_SEL_BASE + r.mode[MODE_BIT_LSB +: 3]];
  assign cnt_mode = r.edge_sel[EDGE_CNT_BIT] ? EM_FALL : EM_RISE;

  tir_edge u_cnt_edge (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .level_i (sel_bit),
    .mode_i  (cnt_mode),
    .pulse_o (cnt_pulse)
  );

  // the pin chosen for each pair is set outside this block
  assign pair1_lvl = PAIR1_USE_A4_I ? PIN_A4_I : PIN_B0_I;
  assign pair2_lvl = PAIR2_USE_B5_I ? PIN_B5_I : PIN_A0_I;

  tir_edge u_pair1_edge (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .level_i (pair1_lvl),
    .mode_i  (tir_edge_t'(r.edge_sel[EDGE_P1_LSB +: 2])),
    .pulse_o (pair1_pulse)
  );

  tir_edge u_pair2_edge (
    .clk_i   (CLK_I),
    .rst_b_i (RST_B_I),
    .level_i (pair2_lvl),
    .mode_i  (tir_edge_t'(r.edge_sel[EDGE_P2_LSB +: 2])),
    .pulse_o (pair2_pulse)
  );

  always_comb begin
    set_vec             = '0;
    set_vec[SRC_TIMER_THREE] = TIMER_THREE_EVT_I;
    set_vec[SRC_TIMER_TWO] = TIMER_TWO_EVT_I;
    set_vec[SRC_PWM]    = PWM_EVT_I;
    set_vec[SRC_CMP]    = CMP_EVT_I;
    set_vec[SRC_ADC]    = ADC_EVT_I;
    set_vec[SRC_CNT]    = cnt_pulse;
    set_vec[SRC_PAIR1]  = pair1_pulse;
    set_vec[SRC_PAIR2]  = pair2_pulse;
  end

  // ************************************************************
  // register bus and request flags
  // ************************************************************
  assign wr_do   = (r.wst == WS_COLLECT) && r.aw_got && r.w_got;
  assign clr_vec = (wr_do && r.wlane && r.waddr == byte_addr(IDX_REQUEST))
                   ? r.wdata : '0;

  always_comb begin
    next_r     = r;
    // set wins over a clear in the same cycle
    next_r.req = (r.req & ~clr_vec) | set_vec;
    unique case (r.wst)
      WS_COLLECT: begin
        if (AWVALID_I && !r.aw_got) begin
          next_r.aw_got = 1'b1;
          next_r.waddr  = AWADDR_I;
        end
        if (WVALID_I && !r.w_got) begin
          next_r.w_got = 1'b1;
          next_r.wdata = WDATA_I[REG_W-1:0];
          next_r.wlane = WSTRB_I[0];
        end
        if (wr_do) begin
          next_r.aw_got = 1'b0;
          next_r.w_got  = 1'b0;
          next_r.wst    = WS_RESP;
          next_r.bresp  = is_mapped(r.waddr) ? RESP_OKAY : RESP_SLVERR;
          if (r.wlane && r.waddr == byte_addr(IDX_ENABLE)) begin
            next_r.en = r.wdata;
          end
          if (r.wlane && r.waddr == byte_addr(IDX_MODE)) begin
            next_r.mode = r.wdata;
          end
          if (r.wlane && r.waddr == byte_addr(IDX_EDGE)) begin
            next_r.edge_sel = r.wdata[EDGE_W-1:0];
          end
        end
      end
      WS_RESP: begin
        if (BREADY_I) begin
          next_r.wst = WS_COLLECT;
        end
      end
      default: begin
        next_r.wst = WS_COLLECT;
      end
    endcase
    unique case (r.rdst)
      RS_IDLE: begin
        if (ARVALID_I) begin
          next_r.rdata = read_mux(ARADDR_I, r, count);
          next_r.rresp = is_mapped(ARADDR_I) ? RESP_OKAY : RESP_SLVERR;
          next_r.rdst  = RS_DATA;
        end
      end
      RS_DATA: begin
        if (RREADY_I) begin
          next_r.rdst = RS_IDLE;
        end
      end
      default: begin
        next_r.rdst = RS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_B_I) begin
      r <= RESET_STATE;
    end else begin
      r <= next_r;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  assign AWREADY_O = (r.wst == WS_COLLECT) && !r.aw_got;
  assign WREADY_O  = (r.wst == WS_COLLECT) && !r.w_got;
  assign BVALID_O  = (r.wst == WS_RESP);
  assign BRESP_O   = r.bresp;
  assign ARREADY_O = (r.rdst == RS_IDLE);
  assign RVALID_O  = (r.rdst == RS_DATA);
  assign RDATA_O   = {{(DATA_W-REG_W){1'b0}}, r.rdata};
  assign RRESP_O   = r.rresp;
  assign IRQ_O     = |(r.req & r.en);

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_B_I);

  logic [N_SRC-1:0] req_q;
  logic [N_SRC-1:0] en_q;
  logic [2:0]       clk_src;
  assign req_q   = r.req;
  assign en_q    = r.en;
  assign clk_src = r.mode[MODE_SRC_LSB +: 3];

  flag_set_a: assert property (
    (set_vec != '0) |=> ((req_q & $past(set_vec)) == $past(set_vec)))
    else $error("request flag not set by its event");

  no_self_clear_a: assert property (
    1'b1 |=> (($past(req_q) & ~req_q & ~$past(clr_vec)) == '0))
    else $error("request flag cleared without a write");

  set_wins_a: assert property (
    ((set_vec & clr_vec) != '0) |=>
      ((req_q & $past(set_vec)) == $past(set_vec)))
    else $error("clear beat a set in the same cycle");

  write_clear_a: assert property (
    (clr_vec != '0) |=> ((req_q & $past(clr_vec) & ~$past(set_vec)) == '0))
    else $error("write of one did not clear the flag");

  irq_gate_a: assert property (
    IRQ_O == ((req_q & en_q) != '0))
    else $error("interrupt output disagrees with enable");

  cnt_rise_a: assert property (
    (!r.edge_sel[EDGE_CNT_BIT] && $rose(sel_bit)) |=> req_q[SRC_CNT])
    else $error("counter bit rise did not raise the event");

  cnt_fall_only_a: assert property (
    (r.edge_sel[EDGE_CNT_BIT] && $rose(sel_bit) && !req_q[SRC_CNT])
      |=> !req_q[SRC_CNT])
    else $error("counter event on wrong edge");

  pair1_fall_a: assert property (
    (r.edge_sel[EDGE_P1_LSB +: 2] == EM_FALL && $rose(pair1_lvl) &&
     !req_q[SRC_PAIR1]) |=> !req_q[SRC_PAIR1])
    else $error("pair one fired on a rise in fall mode");

  pair2_both_a: assert property (
    (r.edge_sel[EDGE_P2_LSB +: 2] == EM_BOTH && $changed(pair2_lvl))
      |=> req_q[SRC_PAIR2])
    else $error("pair two missed an edge in both mode");

  cnt_stop_a: assert property (
    (clk_src == CS_STOP) |=> (count == $past(count)))
    else $error("counter moved while stopped");

  cnt_div4_a: assert property (
    (clk_src == CS_SYS && r.mode[MODE_DIV_LSB +: 2] == 2'h1 &&
     $changed(count)) ##1 (clk_src == CS_SYS) |-> $stable(count))
    else $error("divide by four counted too early");

  bresp_hold_a: assert property (
    (BVALID_O && !BREADY_I) |=> (BVALID_O && $stable(BRESP_O)))
    else $error("write response dropped before taken");

  cnt_event_c: cover property (cnt_pulse ##1 req_q[SRC_CNT]);
  set_clear_c: cover property ((set_vec & clr_vec) != '0);
  irq_rise_c:  cover property ($rose(IRQ_O));
  pair_both_c: cover property (pair1_pulse && pair2_pulse);

endmodule
`default_nettype wire

/* dv/tir_src_model.sv */
// peripheral source model: one-cycle event pulses and free rc ticks.
// assumes the block's clock only.
`timescale 1ns/1ps
`default_nettype none
module tir_src_model (
  // clock
  input  wire logic       clk_i,
  // pulse requests from the bench
  input  wire logic [4:0] fire_i,
  // pulses and ticks to the block
  output logic      [4:0] evt_o,
  output logic      [2:0] tick_o
);
  logic [4:0] prev = 5'h00;
  logic [4:0] cnt  = 5'h00;
  // ************************************************************
  // sources
  // ************************************************************
  always_ff @(posedge clk_i) begin
    prev   <= fire_i;
    evt_o  <= fire_i & ~prev;
    cnt    <= (cnt == 5'h1D) ? 5'h00 : cnt + 5'h01;
    // rates 1/2, 1/3, 1/5 share one wrap at 30
    tick_o <= {cnt % 5'h02 == 5'h00, cnt % 5'h03 == 5'h00,
               cnt % 5'h05 == 5'h00};
  end
endmodule
`default_nettype wire

/* dv/tir_top_tb.sv */
// self-checking bench for the interrupt request block.
// assumes the source model and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tir_top_tb;
  import tir_pkg::*;
  localparam logic [7:0] A_EN = {IDX_ENABLE, 2'h0};
  localparam logic [7:0] A_RQ = {IDX_REQUEST, 2'h0};
  localparam logic [7:0] A_MD = {IDX_MODE, 2'h0};
  localparam logic [7:0] A_EG = {IDX_EDGE, 2'h0};
  localparam logic [7:0] A_CL = {IDX_COUNT_L, 2'h0};
  logic        CLK_I = 1'b0;
  logic        RST_B_I = 1'b0;
  logic        AWVALID_I = 1'b0, WVALID_I = 1'b0, BREADY_I = 1'b0;
  logic        ARVALID_I = 1'b0, RREADY_I = 1'b0;
  logic [7:0]  AWADDR_I = 8'h00, ARADDR_I = 8'h00;
  logic [31:0] WDATA_I = 32'h0;
  logic [3:0]  WSTRB_I = 4'hF;
  logic [3:0]  pins = 4'h0;
  logic [4:0]  fire = 5'h00;
  logic        use_a4 = 1'b0, use_b5 = 1'b0;
  logic        AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, IRQ_O;
  logic [1:0]  BRESP_O, RRESP_O;
  logic [31:0] RDATA_O;
  logic [4:0]  evt;
  logic [2:0]  tick;
  int          mismatches = 0;
  int          checks = 0;
  int          cyc = 0;
  logic [7:0]  ad [4] = '{A_EN, A_RQ, A_MD, A_EG};
  logic [7:0]  md [9] = '{8'h20, 8'h28, 8'h30, 8'h80, 8'hA0, 8'hC0, 8'h22,
                          8'h00, 8'h40};
  int          pe [9] = '{512, 2048, 8192, 1024, 1536, 2560, 2048, 0, 0};
  logic [8:0]  fl = 9'h012;

  always #20 CLK_I = ~CLK_I;
  always @(posedge CLK_I) cyc <= cyc + 1;

  tir_src_model i_tir_src_model (.clk_i(CLK_I), .fire_i(fire),
    .evt_o(evt), .tick_o(tick));
  tir_top i_tir_top (
    .CLK_I(CLK_I), .RST_B_I(RST_B_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .AWADDR_I(AWADDR_I), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(WSTRB_I),
    .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .BRESP_O(BRESP_O),
    .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .ARADDR_I(ARADDR_I),
    .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .TIMER_THREE_EVT_I(evt[4]),
    .TIMER_TWO_EVT_I(evt[3]), .PWM_EVT_I(evt[2]), .CMP_EVT_I(evt[1]),
    .ADC_EVT_I(evt[0]), .HRC_TICK_I(tick[2]), .EXTERNAL_OSCILLATOR_TICK_I(tick[1]),
    .LRC_TICK_I(tick[0]), .PIN_B0_I(pins[0]), .PIN_A4_I(pins[1]),
    .PIN_A0_I(pins[2]), .PIN_B5_I(pins[3]), .PAIR1_USE_A4_I(use_a4),
    .PAIR2_USE_B5_I(use_b5), .IRQ_O(IRQ_O));

  // ************************************************************
  // checking and bus tasks
  // ************************************************************
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t %s got %0h exp %0h", $time, m, g, e);
    end
  endtask

  task automatic hang();
    mismatches++;
    $display("[ERR] %0t wait ran out", $time);
    end_of_test();
  endtask

  // each channel held until its own ready is sampled
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] resp = RESP_OKAY);
    int n;
    @(posedge CLK_I);
    AWVALID_I <= 1'b1;
    AWADDR_I  <= a;
    WVALID_I  <= 1'b1;
    WDATA_I   <= {24'h0, d};
    BREADY_I  <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
      if (AWVALID_I && AWREADY_O) AWVALID_I <= 1'b0;
      if (WVALID_I && WREADY_O) WVALID_I <= 1'b0;
    end while (BVALID_O !== 1'b1 && n < 50);
    if (n >= 50) hang();
    BREADY_I <= 1'b0;
    chk(32'(BRESP_O), 32'(resp), "write response");
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge CLK_I);
    ARVALID_I <= 1'b1;
    ARADDR_I  <= a;
    RREADY_I  <= 1'b1;
    n = 0;
    do begin
      @(posedge CLK_I);
      n++;
      if (ARVALID_I && ARREADY_O) ARVALID_I <= 1'b0;
    end while (RVALID_O !== 1'b1 && n < 50);
    if (n >= 50) hang();
    d = RDATA_O;
    r = RRESP_O;
    RREADY_I <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, {24'h0, e}, "read data");
    chk(32'(r), 32'(RESP_OKAY), "read response");
  endtask

  // spacing of counter events seen on the interrupt line
  task automatic per(input int e);
    int n;
    int t;
    n = 0;
    if (e == 0) begin
      repeat (1300) @(posedge CLK_I);
      chk(32'(IRQ_O), 32'h0, "stopped counter");
      return;
    end
    do begin
      @(posedge CLK_I);
      n++;
    end while (IRQ_O !== 1'b1 && n < e + 100);
    if (IRQ_O !== 1'b1) hang();
    t = cyc;
    wr(A_RQ, 8'h04);
    do begin
      @(posedge CLK_I);
      n++;
    end while (IRQ_O !== 1'b1 && n < 3 * e);
    if (n >= 3 * e) hang();
    chk(32'(cyc - t), 32'(e), "event period");
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  en, e, v;
    void'($urandom(95573));
    {use_a4, use_b5} <= 2'($urandom);
    repeat (8) @(posedge CLK_I);
    RST_B_I <= 1'b1;
    foreach (ad[i]) rchk(ad[i], 8'h00);
    rd(8'h3C, d, r);
    chk(32'(r), 32'(RESP_SLVERR), "unmapped read");
    wr(8'h3C, 8'hFF, RESP_SLVERR);
    v = {3'h0, 5'($urandom)};
    wr(A_MD, v);
    rchk(A_MD, v);
    $display("register test done");
    en = 8'($urandom);
    wr(A_EN, en);
    rchk(A_EN, en);
    e = 8'h00;
    for (int k = 0; k < 5; k++) begin
      @(posedge CLK_I);
      fire <= 5'h01 << k;
      repeat (4) @(posedge CLK_I);
      fire <= 5'h00;
      e = e | (8'h08 << k);
      rchk(A_RQ, e);
      chk(32'(IRQ_O), 32'(|(e & en)), "irq level");
    end
    wr(A_RQ, 8'hA8);
    rchk(A_RQ, 8'h50);
    wr(A_RQ, 8'hFF);
    rchk(A_RQ, 8'h00);
    chk(32'(IRQ_O), 32'h0, "irq after clear");
    // pulse lands on the edge that writes the clear
    fork
      wr(A_RQ, 8'h08);
      begin
        @(posedge CLK_I);
        fire <= 5'h01;
      end
    join
    fire <= 5'h00;
    rchk(A_RQ, 8'h08);
    $display("event test done");
    for (int m = 0; m < 4; m++) begin
      wr(A_EG, {4'h0, 2'(m), 2'(m)});
      wr(A_RQ, 8'hFF);
      @(posedge CLK_I);
      pins <= 4'hF;
      repeat (4) @(posedge CLK_I);
      rchk(A_RQ, (m < 2) ? 8'h03 : 8'h00);
      wr(A_RQ, 8'hFF);
      @(posedge CLK_I);
      pins <= 4'h0;
      repeat (4) @(posedge CLK_I);
      rchk(A_RQ, (m % 2 == 0) ? 8'h03 : 8'h00);
    end
    rchk(A_EG, 8'h00);
    // only the selected pin of each pair may raise its flag
    wr(A_EG, 8'h00);
    wr(A_RQ, 8'hFF);
    @(posedge CLK_I);
    pins <= 4'hA;
    repeat (4) @(posedge CLK_I);
    rchk(A_RQ, {6'h0, use_a4, use_b5});
    pins <= 4'h0;
    $display("pin edge test done");
    wr(A_EN, 8'h04);
    for (int i = 0; i < 9; i++) begin
      wr(A_EG, {3'h0, fl[i], 4'h0});
      wr(A_MD, md[i]);
      wr(A_RQ, 8'hFF);
      per(pe[i]);
    end
    // pin sources count each falling edge
    for (int s = 0; s < 2; s++) begin
      wr(A_MD, s ? 8'hE0 : 8'h60);
      rd(A_CL, d, r);
      v = 8'(1 + $urandom % 20);
      repeat (v) begin
        @(posedge CLK_I);
        pins[1 + s] <= 1'b1;
        @(posedge CLK_I);
        pins[1 + s] <= 1'b0;
      end
      rchk(A_CL, 8'(d[7:0] + v));
    end
    $display("counter test done");
    end_of_test();
  end
endmodule
`default_nettype wire
